// ### cio_pkg.sv
// Shared constants and types for the camera I/O conditioning block
package cio_pkg;
  // Line indices of the three sensed lines
  localparam int NLINE = 3;
  localparam int L_A   = 0;
  localparam int L_B   = 1;
  localparam int L_ISO = 2;

  // Clock and debounce time base
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_TIME_NS  = 1000;
  localparam int CYC_PER_TICK  = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int SUB_W         = 8;
  localparam int DB_W          = 16;

  // Register byte addresses
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] A_CTRL  = 6'h00;
  localparam logic [ADDR_W-1:0] A_OUT   = 6'h04;
  localparam logic [ADDR_W-1:0] A_IN    = 6'h08;
  localparam logic [ADDR_W-1:0] A_RISE  = 6'h0c;
  localparam logic [ADDR_W-1:0] A_FALL  = 6'h10;
  localparam logic [ADDR_W-1:0] A_RMASK = 6'h14;
  localparam logic [ADDR_W-1:0] A_FMASK = 6'h18;
  localparam logic [ADDR_W-1:0] A_DB0   = 6'h20;
  localparam logic [ADDR_W-1:0] A_DB1   = 6'h24;
  localparam logic [ADDR_W-1:0] A_DB2   = 6'h28;

  // Field positions
  localparam int CTRL_DIR_A = 0;
  localparam int CTRL_DIR_B = 1;
  localparam int OUT_ISO    = 2;
  localparam int IN_EN_BIT  = 8;

  // Reset values, filter-off interval value and responses
  localparam logic [1:0]      DIR_RST  = 2'h0;
  localparam logic [2:0]      OUT_RST  = 3'h0;
  localparam logic [2:0]      MASK_RST = 3'h0;
  localparam logic [DB_W-1:0] DB_RST   = 16'h0000;
  localparam logic [DB_W-1:0] DB_OFF   = 16'h0000;
  localparam logic [1:0]      RESP_OK  = 2'h0;
  localparam logic [1:0]      RESP_ERR = 2'h2;

  typedef struct packed {
    logic              prev;
    logic              filt;
    logic [SUB_W-1:0]  sub;
    logic [DB_W-1:0]   us;
  } cio_db_state_t;
endpackage

// ### cio_debounce.sv
// Debounce filter for one synchronised input line
`timescale 1ns/1ps
module cio_debounce (
  input  wire logic                     clk_in,
  input  wire logic                     srst_in,
  input  wire logic                     level_in,
  input  wire logic [cio_pkg::DB_W-1:0] interval_in,
  output logic                          level_out
);
  localparam logic [cio_pkg::SUB_W-1:0] SUB_LAST =
    cio_pkg::SUB_W'(cio_pkg::CYC_PER_TICK - 1);

  cio_pkg::cio_db_state_t s_r;
  cio_pkg::cio_db_state_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.prev = level_in;
    if (interval_in == cio_pkg::DB_OFF) begin
      s_nxt.filt = level_in;
      s_nxt.sub  = '0;
      s_nxt.us   = '0;
    end else if (level_in != s_r.prev || level_in == s_r.filt) begin
      s_nxt.sub = '0;
      s_nxt.us  = '0;
    end else if (s_r.sub == SUB_LAST) begin
      s_nxt.sub = '0;
      if (s_r.us >= interval_in - 16'h0001) begin
        s_nxt.filt = level_in;
        s_nxt.us   = '0;
      end else begin
        s_nxt.us = s_r.us + 16'h0001;
      end
    end else begin
      s_nxt.sub = s_r.sub + 8'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level_out = s_r.filt;
endmodule

// ### cio_top.sv
// Camera I/O port conditioning with AXI4-Lite register access
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
// How it works
// - Two direction-selectable lines, one isolated input, one isolated output.
// - From reset all lines are undriven and unsensed.
// - Lines enable by themselves once bus enumeration completes.
// - Filter passes a new level only after it held for the interval.
// - Filtered level lags the stable raw level by the interval plus two to three clock cycles.
// - Interval in 1 us steps, 0 to 65535; zero bypasses the filter.
// - Every sensed line has its own filter and own interval.
// - Separate rising and falling flags per line, read independently.
// - Reading a flag register returns it and clears it.
// - Repeated same-polarity edges leave one flag set, no count kept.
// - Both two-way lines start as inputs, each switchable to output.
module cio_top (
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        enum_done_in,
  input  wire logic        bidir_line_a_in,
  output logic             bidir_line_a_out,
  output logic             bidir_line_a_oe_out,
  input  wire logic        bidir_line_b_in,
  output logic             bidir_line_b_out,
  output logic             bidir_line_b_oe_out,
  input  wire logic        isolated_input_line_in,
  output logic             isolated_output_line_out,
  output logic             isolated_output_line_oe_out,
  output logic             irq_out,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_awaddr_in,
  input  wire logic [2:0]  s_axi_awprot_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  output logic [1:0]       s_axi_bresp_out,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  input  wire logic [31:0] s_axi_araddr_in,
  input  wire logic [2:0]  s_axi_arprot_in,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out
);
  localparam int N  = cio_pkg::NLINE;
  localparam int DW = cio_pkg::DB_W;
  localparam int AW = cio_pkg::ADDR_W;

  typedef struct packed {
    logic [N-1:0]         sync1;
    logic [N-1:0]         sync2;
    logic [N-1:0]         filt_d;
    logic                 en;
    logic [1:0]           dir;
    logic [N-1:0]         outv;
    logic [N-1:0]         oe;
    logic [N-1:0][DW-1:0] db;
    logic [N-1:0]         rise;
    logic [N-1:0]         fall;
    logic [N-1:0]         rmask;
    logic [N-1:0]         fmask;
    logic                 irq;
    logic                 aw_ok;
    logic [AW-1:0]        awaddr;
    logic                 w_ok;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
  } cio_top_state_t;

  cio_top_state_t s_r;
  cio_top_state_t s_nxt;

  logic [N-1:0] raw;
  logic [N-1:0] filt;
  logic [N-1:0] rise_set;
  logic [N-1:0] fall_set;
  logic [N-1:0] rise_clr;
  logic [N-1:0] fall_clr;
  logic         awready;
  logic         wready;
  logic         arready;

  assign raw = {isolated_input_line_in, bidir_line_b_in, bidir_line_a_in};

  // One independent filter per sensed line
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_line
      cio_debounce u_deb (
        .clk_in      (clk_in),
        .srst_in     (srst_in),
        .level_in    (s_r.sync2[gi] & s_r.en),
        .interval_in (s_r.db[gi]),
        .level_out   (filt[gi])
      );
    end
  endgenerate

  // Byte-lane merge of a write into a 16-bit field
  function automatic logic [15:0] wr16(
    input logic [15:0] old,
    input logic [31:0] d,
    input logic [3:0]  strb
  );
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = d[7:0];
    end
    if (strb[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // Byte-lane merge of a write into a 3-bit field
  function automatic logic [2:0] wr3(
    input logic [2:0]  old,
    input logic [31:0] d,
    input logic [3:0]  strb
  );
    logic [2:0] r;
    r = old;
    if (strb[0]) begin
      r = d[2:0];
    end
    return r;
  endfunction

  assign awready = !s_r.aw_ok && !s_r.bvalid;
  assign wready  = !s_r.w_ok && !s_r.bvalid;
  assign arready = !s_r.rvalid;

  always_comb begin
    s_nxt    = s_r;
    rise_clr = '0;
    fall_clr = '0;

    // Pins double synchronised first; sensing is gated after the second stage
    s_nxt.sync1  = raw;
    s_nxt.sync2  = s_r.sync1;
    s_nxt.filt_d = filt;
    if (enum_done_in) begin
      s_nxt.en = 1'b1;
    end

    // Edge events from the filtered level
    rise_set = s_r.en ? (filt & ~s_r.filt_d) : '0;
    fall_set = s_r.en ? (~filt & s_r.filt_d) : '0;

    // Drivers stay off until enabled; two-way lines follow direction
    s_nxt.oe[cio_pkg::L_A]   = s_r.en & s_r.dir[cio_pkg::CTRL_DIR_A];
    s_nxt.oe[cio_pkg::L_B]   = s_r.en & s_r.dir[cio_pkg::CTRL_DIR_B];
    s_nxt.oe[cio_pkg::L_ISO] = s_r.en;

    // Write address and data taken in either order
    if (s_axi_awvalid_in && awready) begin
      s_nxt.aw_ok  = 1'b1;
      s_nxt.awaddr = s_axi_awaddr_in[AW-1:0];
    end
    if (s_axi_wvalid_in && wready) begin
      s_nxt.w_ok  = 1'b1;
      s_nxt.wdata = s_axi_wdata_in;
      s_nxt.wstrb = s_axi_wstrb_in;
    end
    if (s_r.aw_ok && s_r.w_ok && !s_r.bvalid) begin
      s_nxt.aw_ok  = 1'b0;
      s_nxt.w_ok   = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = cio_pkg::RESP_OK;
      case (s_r.awaddr)
        cio_pkg::A_CTRL: begin
          if (s_r.wstrb[0]) begin
            s_nxt.dir = s_r.wdata[1:0];
          end
        end
        cio_pkg::A_OUT: begin
          s_nxt.outv = wr3(s_r.outv, s_r.wdata, s_r.wstrb);
        end
        cio_pkg::A_IN: begin
        end
        cio_pkg::A_RISE: begin
        end
        cio_pkg::A_FALL: begin
        end
        cio_pkg::A_RMASK: begin
          s_nxt.rmask = wr3(s_r.rmask, s_r.wdata, s_r.wstrb);
        end
        cio_pkg::A_FMASK: begin
          s_nxt.fmask = wr3(s_r.fmask, s_r.wdata, s_r.wstrb);
        end
        cio_pkg::A_DB0: begin
          s_nxt.db[0] = wr16(s_r.db[0], s_r.wdata, s_r.wstrb);
        end
        cio_pkg::A_DB1: begin
          s_nxt.db[1] = wr16(s_r.db[1], s_r.wdata, s_r.wstrb);
        end
        cio_pkg::A_DB2: begin
          s_nxt.db[2] = wr16(s_r.db[2], s_r.wdata, s_r.wstrb);
        end
        default: begin
          s_nxt.bresp = cio_pkg::RESP_ERR;
        end
      endcase
    end
    if (s_r.bvalid && s_axi_bready_in) begin
      s_nxt.bvalid = 1'b0;
    end

    // Read: answer registered, flag registers clear as they are read
    if (s_axi_arvalid_in && arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = cio_pkg::RESP_OK;
      s_nxt.rdata  = '0;
      case (s_axi_araddr_in[AW-1:0])
        cio_pkg::A_CTRL: begin
          s_nxt.rdata[1:0] = s_r.dir;
        end
        cio_pkg::A_OUT: begin
          s_nxt.rdata[N-1:0] = s_r.outv;
        end
        cio_pkg::A_IN: begin
          s_nxt.rdata[N-1:0]             = filt;
          s_nxt.rdata[cio_pkg::IN_EN_BIT] = s_r.en;
        end
        cio_pkg::A_RISE: begin
          s_nxt.rdata[N-1:0] = s_r.rise;
          rise_clr           = '1;
        end
        cio_pkg::A_FALL: begin
          s_nxt.rdata[N-1:0] = s_r.fall;
          fall_clr           = '1;
        end
        cio_pkg::A_RMASK: begin
          s_nxt.rdata[N-1:0] = s_r.rmask;
        end
        cio_pkg::A_FMASK: begin
          s_nxt.rdata[N-1:0] = s_r.fmask;
        end
        cio_pkg::A_DB0: begin
          s_nxt.rdata[DW-1:0] = s_r.db[0];
        end
        cio_pkg::A_DB1: begin
          s_nxt.rdata[DW-1:0] = s_r.db[1];
        end
        cio_pkg::A_DB2: begin
          s_nxt.rdata[DW-1:0] = s_r.db[2];
        end
        default: begin
          s_nxt.rresp = cio_pkg::RESP_ERR;
        end
      endcase
    end
    if (s_r.rvalid && s_axi_rready_in) begin
      s_nxt.rvalid = 1'b0;
    end

    // Sticky flags; a new edge wins over a clearing read
    s_nxt.rise = (s_r.rise & ~rise_clr) | rise_set;
    s_nxt.fall = (s_r.fall & ~fall_clr) | fall_set;
    s_nxt.irq  = |((s_nxt.rise & s_nxt.rmask) | (s_nxt.fall & s_nxt.fmask));
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s_r       <= '0;
      s_r.dir   <= cio_pkg::DIR_RST;
      s_r.outv  <= cio_pkg::OUT_RST;
      s_r.rmask <= cio_pkg::MASK_RST;
      s_r.fmask <= cio_pkg::MASK_RST;
      s_r.db    <= {N{cio_pkg::DB_RST}};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Pin drive
  assign bidir_line_a_out            = s_r.outv[cio_pkg::L_A];
  assign bidir_line_a_oe_out         = s_r.oe[cio_pkg::L_A];
  assign bidir_line_b_out            = s_r.outv[cio_pkg::L_B];
  assign bidir_line_b_oe_out         = s_r.oe[cio_pkg::L_B];
  assign isolated_output_line_out    = s_r.outv[cio_pkg::OUT_ISO];
  assign isolated_output_line_oe_out = s_r.oe[cio_pkg::L_ISO];
  assign irq_out                     = s_r.irq;

  // Bus handshake and answers
  assign s_axi_awready_out = awready;
  assign s_axi_wready_out  = wready;
  assign s_axi_bvalid_out  = s_r.bvalid;
  assign s_axi_bresp_out   = s_r.bresp;
  assign s_axi_arready_out = arready;
  assign s_axi_rvalid_out  = s_r.rvalid;
  assign s_axi_rdata_out   = s_r.rdata;
  assign s_axi_rresp_out   = s_r.rresp;
endmodule

// ### cio_top_properties.sv
// Port-level assertions for the camera I/O conditioning block
`timescale 1ns/1ps
module cio_top_properties (
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic enum_done_in,
  input  wire logic bidir_line_a_oe_out,
  input  wire logic bidir_line_b_oe_out,
  input  wire logic isolated_output_line_oe_out,
  input  wire logic irq_out,
  input  wire logic s_axi_arvalid_in,
  input  wire logic s_axi_arready_out,
  input  wire logic s_axi_rvalid_out
);
  logic seen_r;
  always_ff @(posedge clk_in) seen_r <= srst_in ? 1'h0 : (seen_r | enum_done_in);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  property p_off;
    !seen_r |-> !(bidir_line_a_oe_out | bidir_line_b_oe_out | isolated_output_line_oe_out);
  endproperty
  a_off: assert property (p_off) else $error("line driven before enable");
  property p_auto; enum_done_in && !seen_r |-> ##[1:3] isolated_output_line_oe_out; endproperty
  a_auto: assert property (p_auto) else $error("lines not enabled");
  property p_keep; isolated_output_line_oe_out |=> isolated_output_line_oe_out; endproperty
  a_keep: assert property (p_keep) else $error("enable dropped");
  property p_dir; $past(srst_in) |-> !bidir_line_a_oe_out && !bidir_line_b_oe_out; endproperty
  a_dir: assert property (p_dir) else $error("two-way line not input after reset");
  property p_gate; bidir_line_a_oe_out || bidir_line_b_oe_out |-> isolated_output_line_oe_out;
  endproperty
  a_gate: assert property (p_gate) else $error("two-way drive while disabled");
  property p_irq; !seen_r |-> !irq_out; endproperty
  a_irq: assert property (p_irq) else $error("interrupt while disabled");
  property p_rd; s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_one; s_axi_rvalid_out |-> !s_axi_arready_out; endproperty
  a_one: assert property (p_one) else $error("read accepted while answering");
endmodule
bind cio_top cio_top_properties chk_u (.*);

// ### cio_ext_model.sv
// Switches and loads wired to the camera I/O connector
`timescale 1ns/1ps
module cio_ext_model (
  input  wire logic sw_a_in,
  input  wire logic sw_b_in,
  input  wire logic sw_iso_in,
  input  wire logic drv_a_in,
  input  wire logic oe_a_in,
  input  wire logic drv_b_in,
  input  wire logic oe_b_in,
  input  wire logic drv_iso_in,
  input  wire logic oe_iso_in,
  output logic      pin_a_out,
  output logic      pin_b_out,
  output logic      pin_iso_out,
  output logic      load_out
);
  assign pin_a_out = oe_a_in ? drv_a_in : sw_a_in;
  assign pin_b_out = oe_b_in ? drv_b_in : sw_b_in;
  assign pin_iso_out = sw_iso_in;
  assign load_out = oe_iso_in ? drv_iso_in : 1'h1;
endmodule

// ### cio_top_tb_top.sv
// Self-checking bench for the camera I/O conditioning block
`timescale 1ns/1ps
module cio_top_tb_top;
  logic clk_in = '0, srst_in = '1, enum_done_in = '0, load, sw_a = '1, sw_b = '0, sw_iso = '1;
  logic bidir_line_a_in, bidir_line_b_in, isolated_input_line_in, irq_out;
  logic bidir_line_a_out, bidir_line_a_oe_out, bidir_line_b_out, bidir_line_b_oe_out;
  logic isolated_output_line_out, isolated_output_line_oe_out;
  logic s_axi_awvalid_in = '0, s_axi_wvalid_in = '0, s_axi_arvalid_in = '0;
  logic s_axi_bready_in = '1, s_axi_rready_in = '1, s_axi_awready_out, s_axi_wready_out;
  logic s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic [31:0] s_axi_awaddr_in = '0, s_axi_wdata_in = '0, s_axi_araddr_in = '0;
  logic [31:0] s_axi_rdata_out, rv;
  logic [2:0] s_axi_awprot_in = '0, s_axi_arprot_in = '0;
  logic [3:0] s_axi_wstrb_in = 4'hf;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rsp;
  int miscompares = 0, checked = 0, c;
  always #2.5 clk_in = ~clk_in;
  cio_top dut_u (.*);
  cio_ext_model ext_u (.sw_a_in(sw_a), .sw_b_in(sw_b), .sw_iso_in(sw_iso),
    .drv_a_in(bidir_line_a_out), .oe_a_in(bidir_line_a_oe_out),
    .drv_b_in(bidir_line_b_out), .oe_b_in(bidir_line_b_oe_out),
    .drv_iso_in(isolated_output_line_out), .oe_iso_in(isolated_output_line_oe_out),
    .pin_a_out(bidir_line_a_in), .pin_b_out(bidir_line_b_in),
    .pin_iso_out(isolated_input_line_in), .load_out(load));
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic ad = 0;
    logic wd = 0;
    s_axi_awaddr_in <= {26'h0, a};
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1;
    s_axi_wvalid_in <= 1;
    while (!(ad && wd)) begin
      @(posedge clk_in);
      if (!ad && s_axi_awready_out) begin
        ad = 1;
        s_axi_awvalid_in <= 0;
      end
      if (!wd && s_axi_wready_out) begin
        wd = 1;
        s_axi_wvalid_in <= 0;
      end
    end
    do begin @(posedge clk_in); end while (!s_axi_bvalid_out);
    rsp = s_axi_bresp_out;
  endtask
  task automatic rd(input logic [5:0] a);
    s_axi_araddr_in <= {26'h0, a};
    s_axi_arvalid_in <= 1;
    do begin @(posedge clk_in); end while (!s_axi_arready_out);
    s_axi_arvalid_in <= 0;
    do begin @(posedge clk_in); end while (!s_axi_rvalid_out);
    rv = s_axi_rdata_out;
    rsp = s_axi_rresp_out;
  endtask
  task automatic rc(input logic [5:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
  endtask
  task automatic lag(input int lo);
    c = 0;
    while (!irq_out && c < 2000) begin @(posedge clk_in); c++; end
    chk(32'(c >= lo && c <= lo + 8), 32'h1);
  endtask
  initial begin
    cyc(4);
    srst_in <= 0;
    cyc(10);
    chk({bidir_line_a_oe_out, bidir_line_b_oe_out, isolated_output_line_oe_out, load}, 4'h1);
    rc(cio_pkg::A_IN, 32'h0);
    rc(cio_pkg::A_CTRL, 32'h0);
    rc(cio_pkg::A_DB0, 32'h0);
    enum_done_in <= 1;
    cyc(1);
    enum_done_in <= 0;
    cyc(10);
    chk(isolated_output_line_oe_out, 1'h1);
    rc(cio_pkg::A_IN, 32'h0000_0105);
    rc(cio_pkg::A_RISE, 32'h5);
    rc(cio_pkg::A_RISE, 32'h0);
    $display("enable test done");
    wr(cio_pkg::A_CTRL, 32'h1);
    wr(cio_pkg::A_OUT, 32'h7);
    chk({bidir_line_a_oe_out, bidir_line_b_oe_out, bidir_line_a_out, load}, 4'hb);
    wr(cio_pkg::A_CTRL, 32'h2);
    cyc(1);
    chk({bidir_line_a_oe_out, bidir_line_b_oe_out, bidir_line_b_out}, 3'h3);
    wr(cio_pkg::A_CTRL, 32'h0);
    wr(cio_pkg::A_OUT, 32'h0);
    wr(6'h3c, 32'h1);
    chk(rsp, cio_pkg::RESP_ERR);
    rd(6'h3c);
    chk(rsp, cio_pkg::RESP_ERR);
    wr(cio_pkg::A_IN, 32'h0);
    chk(rsp, cio_pkg::RESP_OK);
    cyc(10);
    rd(cio_pkg::A_RISE);
    rd(cio_pkg::A_FALL);
    $display("direction test done");
    repeat (2) begin
      sw_iso <= 0;
      cyc(6);
      sw_iso <= 1;
      cyc(6);
    end
    rc(cio_pkg::A_RISE, 32'h4);
    rc(cio_pkg::A_FALL, 32'h4);
    rc(cio_pkg::A_RISE, 32'h0);
    wr(cio_pkg::A_RMASK, 32'h4);
    sw_iso <= 0;
    cyc(6);
    chk(irq_out, 1'h0);
    sw_iso <= 1;
    cyc(6);
    chk(irq_out, 1'h1);
    rc(cio_pkg::A_RISE, 32'h4);
    chk(irq_out, 1'h0);
    rd(cio_pkg::A_FALL);
    $display("event test done");
    wr(cio_pkg::A_DB0, 32'h1);
    wr(cio_pkg::A_DB1, 32'h3);
    wr(cio_pkg::A_RMASK, 32'h3);
    sw_a <= 0;
    cyc(300);
    rd(cio_pkg::A_FALL);
    sw_a <= 1;
    cyc(150);
    sw_a <= 0;
    cyc(10);
    sw_a <= 1;
    lag(200);
    rc(cio_pkg::A_RISE, 32'h1);
    sw_b <= 1;
    lag(600);
    rc(cio_pkg::A_RISE, 32'h2);
    rc(cio_pkg::A_DB1, 32'h3);
    wr(cio_pkg::A_DB2, 32'h0000_ffff);
    rc(cio_pkg::A_DB2, 32'h0000_ffff);
    $display("debounce test done");
    srst_in <= 1;
    cyc(4);
    srst_in <= 0;
    cyc(2);
    chk({bidir_line_a_oe_out, bidir_line_b_oe_out, isolated_output_line_oe_out, load}, 4'h1);
    rc(cio_pkg::A_CTRL, 32'h0);
    rc(cio_pkg::A_IN, 32'h0);
    rc(cio_pkg::A_RISE, 32'h0);
    $display("reset test done");
    conclude();
  end
  initial begin
    #60000;
    miscompares++;
    conclude();
  end
endmodule
